// ### hdl/rdc_distance_regs.v
// Configuration register bank for the radar distance detection function
// Function
// - Writable start and length of the measured interval, both in millimetres.
// - Receiver gain 0 to 1000; zero least, 1000 most amplification.
// - Power code 0x00 shuts the sensor down fully between sweeps.
// - Power codes 0x01 sleep, 0x02 ready, 0x03 fully active.
// - Code 0x04 hibernates; the controller toggles a GPIO to enter or leave.
// - Hibernation is sparse-only; the distance function does not use code 0x04.
// - Profile codes 0x01 to 0x05 trade depth resolution against loop gain.
// - Holds count of hardware averaged samples per output data point.
// - Writable flag turns asynchronous measurement on or off.
// - Range code 0x06 gives 11.5 m/7.0 m; 0x09 gives 17.3 m/12.7 m.
// - Sweep averaging count of consecutive sweeps; value 1 disables averaging.
// - Threshold type 0x00 fixed, 0x02 adaptive CFAR.
// - Writable registers configure; read-only ones carry device-refreshed metadata.
`default_nettype none

module rdc_distance_regs #(
    parameter ADDR_W = 8
) (
    input  wire              sys_clk,
    input  wire              rst_n,
    input  wire              reg_wr_en,
    input  wire              reg_rd_en,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [31:0]       reg_wdata,
    output reg  [31:0]       reg_rdata_q,
    output reg               reg_rvalid_q,
    output reg               reg_err_q,
    output reg  [31:0]       measure_begin_mm_q,
    output reg  [31:0]       measure_span_mm_q,
    output reg  [31:0]       receiver_gain_q,
    output reg  [31:0]       radar_power_state_q,
    output reg  [31:0]       path_profile_choice_q,
    output reg  [31:0]       hw_sample_averaging_q,
    output reg               async_measure_enable_q,
    output reg  [31:0]       unambiguous_range_sel_q,
    output reg  [31:0]       sweep_averaging_count_q,
    output reg  [31:0]       peak_threshold_type_q,
    output reg               sweep_averaging_count_active_q,
    output reg               cfar_select_q,
    output reg               config_valid_q,
    output wire              pwr_off_q,
    output wire              pwr_sleep_q,
    output wire              pwr_ready_q,
    output wire              pwr_active_q
);
`include "rdc_consts.vh"

    wire        pwr_valid_q;
    wire [7:0]  status_w;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    // Whole word kept so the flag register reads back what was written; only bit 0 acts
    reg  [31:0] async_word_q;

    // Decodes a register index into a known-address flag
    function is_mapped;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `RDC_ADDR_MEASURE_BEGIN_MM,
                `RDC_ADDR_MEASURE_SPAN_MM,
                `RDC_ADDR_RECEIVER_GAIN,
                `RDC_ADDR_RADAR_POWER_STATE,
                `RDC_ADDR_PATH_PROFILE_CHOICE,
                `RDC_ADDR_HW_SAMPLE_AVERAGING,
                `RDC_ADDR_ASYNC_MEASURE_ENABLE,
                `RDC_ADDR_UNAMBIGUOUS_RANGE_SEL,
                `RDC_ADDR_SWEEP_AVERAGING_COUNT,
                `RDC_ADDR_PEAK_THRESHOLD_TYPE,
                `RDC_ADDR_CFG_STATUS: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    wire wr_hit = reg_wr_en && is_mapped(reg_addr) && (reg_addr != `RDC_ADDR_CFG_STATUS);

    // Writes store the value unchanged; range checks only feed status, so software
    // always reads back exactly what it wrote
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_begin_mm_q      <= `RDC_RST_MEASURE_BEGIN_MM;
            measure_span_mm_q       <= `RDC_RST_MEASURE_SPAN_MM;
            receiver_gain_q         <= `RDC_RST_RECEIVER_GAIN;
            radar_power_state_q     <= `RDC_RST_RADAR_POWER_STATE;
            path_profile_choice_q   <= `RDC_RST_PATH_PROFILE_CHOICE;
            hw_sample_averaging_q   <= `RDC_RST_HW_SAMPLE_AVERAGING;
            async_measure_enable_q  <= 1'b0;
            async_word_q            <= `RDC_RST_ASYNC_MEASURE_ENABLE;
            unambiguous_range_sel_q <= `RDC_RST_UNAMBIGUOUS_RANGE_SEL;
            sweep_averaging_count_q <= `RDC_RST_SWEEP_AVERAGING_COUNT;
            peak_threshold_type_q   <= `RDC_RST_PEAK_THRESHOLD_TYPE;
        end else if (wr_hit) begin
            case (reg_addr)
                `RDC_ADDR_MEASURE_BEGIN_MM:      measure_begin_mm_q      <= reg_wdata;
                `RDC_ADDR_MEASURE_SPAN_MM:       measure_span_mm_q       <= reg_wdata;
                `RDC_ADDR_RECEIVER_GAIN:         receiver_gain_q         <= reg_wdata;
                `RDC_ADDR_RADAR_POWER_STATE:     radar_power_state_q     <= reg_wdata;
                `RDC_ADDR_PATH_PROFILE_CHOICE:   path_profile_choice_q   <= reg_wdata;
                `RDC_ADDR_HW_SAMPLE_AVERAGING:   hw_sample_averaging_q   <= reg_wdata;
                `RDC_ADDR_ASYNC_MEASURE_ENABLE: begin
                    async_word_q           <= reg_wdata;
                    async_measure_enable_q <= reg_wdata[0];
                end
                `RDC_ADDR_UNAMBIGUOUS_RANGE_SEL: unambiguous_range_sel_q <= reg_wdata;
                `RDC_ADDR_SWEEP_AVERAGING_COUNT: sweep_averaging_count_q <= reg_wdata;
                `RDC_ADDR_PEAK_THRESHOLD_TYPE:   peak_threshold_type_q   <= reg_wdata;
                default: ;
            endcase
        end
    end

    rdc_power_decode u_pwr (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .power_code   (radar_power_state_q),
        .pwr_off_q    (pwr_off_q),
        .pwr_sleep_q  (pwr_sleep_q),
        .pwr_ready_q  (pwr_ready_q),
        .pwr_active_q (pwr_active_q),
        .pwr_valid_q  (pwr_valid_q)
    );

    // Derived controls, one cycle behind the stored values; config_valid_q is two behind the power code
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sweep_averaging_count_active_q <= 1'b0;
            cfar_select_q      <= 1'b0;
            config_valid_q     <= 1'b0;
        end else begin
            // Zero is treated like one: no averaging
            sweep_averaging_count_active_q <= (sweep_averaging_count_q > `RDC_SWEEP_AVERAGING_COUNT_OFF);
            cfar_select_q      <= (peak_threshold_type_q == `RDC_THR_CFAR);
            config_valid_q     <= &status_w[`RDC_ST_THR_OK:`RDC_ST_GAIN_OK];
        end
    end

    // Read-only metadata: refreshed by the device, never by a write
    assign status_w[`RDC_ST_GAIN_OK]    = (receiver_gain_q <= `RDC_GAIN_MAX);
    assign status_w[`RDC_ST_PWR_OK]     = pwr_valid_q;
    assign status_w[`RDC_ST_PROFILE_OK] = (path_profile_choice_q >= `RDC_PROFILE_MIN) &&
                                          (path_profile_choice_q <= `RDC_PROFILE_MAX);
    assign status_w[`RDC_ST_MUR_OK]     = (unambiguous_range_sel_q == `RDC_MUR_11P5) ||
                                          (unambiguous_range_sel_q == `RDC_MUR_17P3);
    assign status_w[`RDC_ST_THR_OK]     = (peak_threshold_type_q == `RDC_THR_FIXED) ||
                                          (peak_threshold_type_q == `RDC_THR_CFAR);
    assign status_w[`RDC_ST_SWEEP_AVERAGING_COUNT_ON]     = sweep_averaging_count_active_q;
    assign status_w[`RDC_ST_SHUTDOWN_BETWEEN] = pwr_off_q;
    assign status_w[`RDC_ST_FULL_ACTIVE]      = pwr_active_q;

    always @* begin
        rd_hit = is_mapped(reg_addr);
        case (reg_addr)
            `RDC_ADDR_MEASURE_BEGIN_MM:      rd_mux = measure_begin_mm_q;
            `RDC_ADDR_MEASURE_SPAN_MM:       rd_mux = measure_span_mm_q;
            `RDC_ADDR_RECEIVER_GAIN:         rd_mux = receiver_gain_q;
            `RDC_ADDR_RADAR_POWER_STATE:     rd_mux = radar_power_state_q;
            `RDC_ADDR_PATH_PROFILE_CHOICE:   rd_mux = path_profile_choice_q;
            `RDC_ADDR_HW_SAMPLE_AVERAGING:   rd_mux = hw_sample_averaging_q;
            `RDC_ADDR_ASYNC_MEASURE_ENABLE:  rd_mux = async_word_q;
            `RDC_ADDR_UNAMBIGUOUS_RANGE_SEL: rd_mux = unambiguous_range_sel_q;
            `RDC_ADDR_SWEEP_AVERAGING_COUNT: rd_mux = sweep_averaging_count_q;
            `RDC_ADDR_PEAK_THRESHOLD_TYPE:   rd_mux = peak_threshold_type_q;
            `RDC_ADDR_CFG_STATUS:            rd_mux = {24'h000000, status_w};
            default:                         rd_mux = 32'h00000000;
        endcase
    end

    // Reads return last written value one cycle later; unmapped accesses flag an error
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q  <= 32'h00000000;
            reg_rvalid_q <= 1'b0;
            reg_err_q    <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd_en;
            reg_rdata_q  <= reg_rd_en ? rd_mux : 32'h00000000;
            reg_err_q    <= (reg_rd_en && !rd_hit) ||
                            (reg_wr_en && !wr_hit);
        end
    end

endmodule
`default_nettype wire

// ### hdl/rdc_power_decode.v
// Power state decoder for the distance function
`default_nettype none

module rdc_power_decode (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [31:0] power_code,
    output reg         pwr_off_q,
    output reg         pwr_sleep_q,
    output reg         pwr_ready_q,
    output reg         pwr_active_q,
    output reg         pwr_valid_q
);
`include "rdc_consts.vh"

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_off_q    <= 1'b1;
            pwr_sleep_q  <= 1'b0;
            pwr_ready_q  <= 1'b0;
            pwr_active_q <= 1'b0;
            pwr_valid_q  <= 1'b1;
        end else begin
            pwr_off_q    <= (power_code == `RDC_PWR_OFF);
            pwr_sleep_q  <= (power_code == `RDC_PWR_SLEEP);
            pwr_ready_q  <= (power_code == `RDC_PWR_READY);
            pwr_active_q <= (power_code == `RDC_PWR_ACTIVE);
            // Hibernation is a sparse-only mode, so it is not valid here
            pwr_valid_q  <= (power_code <= `RDC_PWR_ACTIVE);
        end
    end

endmodule
`default_nettype wire

// ### shared/rdc_consts.vh
// Register offsets, field codes and reset values of the distance configuration bank
`ifndef RDC_CONSTS_VH
`define RDC_CONSTS_VH

// Register indices (byte-free word addresses on the register port)
`define RDC_ADDR_MEASURE_BEGIN_MM      8'h20
`define RDC_ADDR_MEASURE_SPAN_MM       8'h21
`define RDC_ADDR_RECEIVER_GAIN         8'h24
`define RDC_ADDR_RADAR_POWER_STATE     8'h25
`define RDC_ADDR_PATH_PROFILE_CHOICE   8'h28
`define RDC_ADDR_HW_SAMPLE_AVERAGING   8'h30
`define RDC_ADDR_ASYNC_MEASURE_ENABLE  8'h33
`define RDC_ADDR_UNAMBIGUOUS_RANGE_SEL 8'h34
`define RDC_ADDR_SWEEP_AVERAGING_COUNT 8'h40
`define RDC_ADDR_PEAK_THRESHOLD_TYPE   8'h41
`define RDC_ADDR_CFG_STATUS            8'h3f

// Receiver gain limits
`define RDC_GAIN_MIN                   32'h00000000
`define RDC_GAIN_MAX                   32'h000003e8

// Power state codes
`define RDC_PWR_OFF                    32'h00000000
`define RDC_PWR_SLEEP                  32'h00000001
`define RDC_PWR_READY                  32'h00000002
`define RDC_PWR_ACTIVE                 32'h00000003
`define RDC_PWR_HIBERNATE              32'h00000004

// Profile codes
`define RDC_PROFILE_MIN                32'h00000001
`define RDC_PROFILE_MAX                32'h00000005

// Unambiguous range codes
`define RDC_MUR_11P5                   32'h00000006
`define RDC_MUR_17P3                   32'h00000009

// Threshold types
`define RDC_THR_FIXED                  32'h00000000
`define RDC_THR_CFAR                   32'h00000002

// Sweep averaging value meaning no averaging
`define RDC_SWEEP_AVERAGING_COUNT_OFF              32'h00000001

// Reset values
`define RDC_RST_MEASURE_BEGIN_MM       32'h00000000
`define RDC_RST_MEASURE_SPAN_MM        32'h00000000
`define RDC_RST_RECEIVER_GAIN          32'h00000000
`define RDC_RST_RADAR_POWER_STATE      32'h00000000
`define RDC_RST_PATH_PROFILE_CHOICE    32'h00000001
`define RDC_RST_HW_SAMPLE_AVERAGING    32'h00000001
`define RDC_RST_ASYNC_MEASURE_ENABLE   32'h00000000
`define RDC_RST_UNAMBIGUOUS_RANGE_SEL  32'h00000006
`define RDC_RST_SWEEP_AVERAGING_COUNT  32'h00000001
`define RDC_RST_PEAK_THRESHOLD_TYPE    32'h00000000

// Status register bit positions
`define RDC_ST_GAIN_OK                 0
`define RDC_ST_PWR_OK                  1
`define RDC_ST_PROFILE_OK              2
`define RDC_ST_MUR_OK                  3
`define RDC_ST_THR_OK                  4
`define RDC_ST_SWEEP_AVERAGING_COUNT_ON            5
`define RDC_ST_SHUTDOWN_BETWEEN        6
`define RDC_ST_FULL_ACTIVE             7

`endif

// ### tb/rdc_distance_regs_chk.sv
// Port assertions for the distance configuration bank
`default_nettype none
`include "rdc_consts.vh"
module rdc_chk #(
    parameter ADDR_W = 8
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_rvalid_q,
    input wire logic              reg_err_q,
    input wire logic [31:0]       measure_begin_mm_q,
    input wire logic [31:0]       measure_span_mm_q,
    input wire logic [31:0]       path_profile_choice_q,
    input wire logic [31:0]       hw_sample_averaging_q,
    input wire logic [31:0]       unambiguous_range_sel_q,
    input wire logic [31:0]       receiver_gain_q,
    input wire logic [31:0]       radar_power_state_q,
    input wire logic [31:0]       peak_threshold_type_q,
    input wire logic [31:0]       sweep_averaging_count_q,
    input wire logic              async_measure_enable_q,
    input wire logic              sweep_averaging_count_active_q,
    input wire logic              cfar_select_q,
    input wire logic              pwr_off_q,
    input wire logic              pwr_active_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd; reg_rd_en; endsequence
    sequence s_wr(a); reg_wr_en && reg_addr == a; endsequence
    a_read_answer: assert property (s_rd |=> reg_rvalid_q) else $error("read not answered");
    a_answer_cause: assert property (reg_rvalid_q |-> $past(reg_rd_en)) else $error("stray read valid");
    a_begin_write: assert property (s_wr(`RDC_ADDR_MEASURE_BEGIN_MM) |=>
        measure_begin_mm_q == $past(reg_wdata)) else $error("start not stored");
    a_span_write: assert property (s_wr(`RDC_ADDR_MEASURE_SPAN_MM) |=>
        measure_span_mm_q == $past(reg_wdata)) else $error("length not stored");
    a_gain_write: assert property (s_wr(`RDC_ADDR_RECEIVER_GAIN) |=>
        receiver_gain_q == $past(reg_wdata)) else $error("gain not stored");
    a_profile_write: assert property (s_wr(`RDC_ADDR_PATH_PROFILE_CHOICE) |=>
        path_profile_choice_q == $past(reg_wdata)) else $error("profile not stored");
    a_hwavg_write: assert property (s_wr(`RDC_ADDR_HW_SAMPLE_AVERAGING) |=>
        hw_sample_averaging_q == $past(reg_wdata)) else $error("sample count not stored");
    a_range_write: assert property (s_wr(`RDC_ADDR_UNAMBIGUOUS_RANGE_SEL) |=>
        unambiguous_range_sel_q == $past(reg_wdata)) else $error("range code not stored");
    a_status_wr_err: assert property (s_wr(`RDC_ADDR_CFG_STATUS) |=> reg_err_q)
        else $error("status write not refused");
    a_async_bit: assert property (s_wr(`RDC_ADDR_ASYNC_MEASURE_ENABLE) |=>
        async_measure_enable_q == $past(reg_wdata[0])) else $error("async flag wrong");
    a_off_decode: assert property (radar_power_state_q == 32'h0 |=> pwr_off_q) else $error("off not decoded");
    a_active_decode: assert property (1'b1 |=>
        pwr_active_q == ($past(radar_power_state_q) == 32'h3)) else $error("active decode wrong");
    a_cfar_decode: assert property (1'b1 |=>
        cfar_select_q == ($past(peak_threshold_type_q) == 32'h2)) else $error("cfar decode wrong");
    a_sweep_active: assert property (1'b1 |=>
        sweep_averaging_count_active_q == ($past(sweep_averaging_count_q) > 32'h1)) else $error("sweep flag wrong");
endmodule
bind rdc_distance_regs rdc_chk #(.ADDR_W(ADDR_W)) i_rdc_chk (.sys_clk, .rst_n, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rvalid_q, .reg_err_q, .measure_begin_mm_q, .measure_span_mm_q,
    .path_profile_choice_q, .hw_sample_averaging_q, .unambiguous_range_sel_q, .receiver_gain_q,
    .radar_power_state_q, .peak_threshold_type_q, .sweep_averaging_count_q, .async_measure_enable_q,
    .sweep_averaging_count_active_q, .cfar_select_q, .pwr_off_q, .pwr_active_q);
`default_nettype wire

// ### tb/rdc_host_model.sv
// Host controller model driving the register port
`default_nettype none
module rdc_host_model (
    input  wire logic        sys_clk,
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
    end
    // Power code 0x04 is only written to see it flagged invalid, so no oscillator toggling
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        reg_wr_en = w;
        reg_rd_en = !w;
        reg_addr = a;
        reg_wdata = w ? d : ~reg_wdata;
    endtask
    // Released lines carry inverted data so a stale value cannot pass
    task automatic idle();
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the distance configuration bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    wire         reg_wr_en, reg_rd_en;
    wire  [7:0]  reg_addr;
    wire  [31:0] reg_wdata;
    logic [31:0] reg_rdata_q;
    logic        reg_rvalid_q, reg_err_q, cfar_select_q, sweep_averaging_count_active_q, config_valid_q;
    logic        pwr_off_q, pwr_sleep_q, pwr_ready_q, pwr_active_q;
    logic [32:0] expq[$];
    int          failures = 0;
    int          checked = 0;
    integer      seed = 32'hb3ae7ffb;
    logic [7:0]  adr [10] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h28, 8'h30, 8'h33, 8'h34, 8'h40, 8'h41};
    logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h6, 32'h1, 32'h0};
    rdc_host_model i_rdc_host_model (.sys_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata);
    rdc_distance_regs i_rdc_distance_regs (.sys_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata_q, .reg_rvalid_q, .reg_err_q, .measure_begin_mm_q(), .measure_span_mm_q(),
        .receiver_gain_q(), .radar_power_state_q(), .path_profile_choice_q(), .hw_sample_averaging_q(),
        .async_measure_enable_q(), .unambiguous_range_sel_q(), .sweep_averaging_count_q(),
        .peak_threshold_type_q(), .sweep_averaging_count_active_q, .cfar_select_q, .config_valid_q,
        .pwr_off_q, .pwr_sleep_q, .pwr_ready_q, .pwr_active_q);
    task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_rdc_host_model.acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        i_rdc_host_model.acc(1'b0, a, 32'h0);
        expq.push_back(e);
    endtask
    task automatic stop_test();
        if (expq.size() != 0) failures++;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Replies stand one cycle, so the falling edge sees each exactly once
    always @(negedge sys_clk) begin
        if (reg_rvalid_q === 1'b1 || reg_err_q === 1'b1) begin
            chk("reply", {reg_err_q, reg_rdata_q}, expq.size() ? expq.pop_front() : 33'hx);
        end
    end
    initial begin
        #20000;
        failures++;
        stop_test();
    end
    initial begin
        logic [31:0] v;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 10; i++) rd(adr[i], {1'b0, rv[i]});
        for (int i = 0; i < 10; i++) begin
            v = $random(seed);
            wr(adr[i], v);
            rd(adr[i], {1'b0, v});
        end
        rd(8'h22, {1'b1, 32'h0});
        wr(8'h3f, v);
        expq.push_back({1'b1, 32'h0});
        wr(8'h24, 32'h3e8);
        wr(8'h28, 32'h5);
        wr(8'h34, 32'h9);
        wr(8'h41, 32'h2);
        wr(8'h40, 32'h2);
        i_rdc_host_model.idle();
        @(negedge sys_clk);
        chk("cfar sweep", {cfar_select_q, sweep_averaging_count_active_q}, 2'b11);
        for (int c = 0; c < 5; c++) begin
            wr(8'h25, c);
            i_rdc_host_model.idle();
            @(negedge sys_clk);
            chk("power", {pwr_off_q, pwr_sleep_q, pwr_ready_q, pwr_active_q}, 4'b1000 >> c);
            @(negedge sys_clk);
            chk("valid", config_valid_q, c < 4);
        end
        // Gain, profile, range and threshold legal, hibernate code refused, averaging on
        rd(8'h3f, {1'b0, 32'h3d});
        wr(8'h40, 32'h1);
        wr(8'h41, 32'h0);
        i_rdc_host_model.idle();
        @(negedge sys_clk);
        chk("cfar sweep", {cfar_select_q, sweep_averaging_count_active_q}, 2'b00);
        rd(8'h3f, {1'b0, 32'h1d});
        i_rdc_host_model.idle();
        repeat (3) @(negedge sys_clk);
        stop_test();
    end
endmodule
`default_nettype wire
